// >>> common/cfg_opt_pkg.sv
package cfg_opt_pkg;

  // ****************************************
  // Option byte layout
  // ****************************************
  localparam int unsigned OPT_W       = 8;
  localparam int unsigned BOD_ON_BIT  = 7;
  localparam int unsigned BOD_SEL_HI  = 5;
  localparam int unsigned BOD_SEL_LO  = 4;
  localparam int unsigned BOD_BLK_BIT = 3;
  localparam int unsigned BOD_RST_BIT = 2;
  localparam int unsigned WDT_HI      = 7;
  localparam int unsigned WDT_LO      = 4;
  localparam int unsigned WDT_W       = 4;

  // Watchdog option codes
  localparam logic [3:0] WDT_CODE_TIMER = 4'hf;
  localparam logic [3:0] WDT_CODE_STOP  = 4'h5;

  // ****************************************
  // Carriers
  // ****************************************
  // Threshold code: highest level at 0, lowest at 3
  typedef enum logic [1:0] {
    LVL_HIGHEST   = 2'h0,
    LVL_UPPER_MID = 2'h1,
    LVL_LOWER_MID = 2'h2,
    LVL_LOWEST    = 2'h3
  } bod_level_e;

  typedef struct packed {
    logic       brownout_detect_on;
    bod_level_e brownout_threshold_sel;
    logic       brownout_blocks_selfprog;
    logic       brownout_reset_on;
  } bod_cfg_s;

  typedef struct packed {
    logic reset_en;
    logic run_in_idle;
    logic timer_only;
  } wdt_cfg_s;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic rst_n;
    logic clk;
    logic dat;
    logic bod_low;
  } pin_s;

  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_RUN  = 2'h1
  } ld_state_e;

  localparam bod_cfg_s BOD_CFG_RST = 5'h00;
  localparam wdt_cfg_s WDT_CFG_RST = 3'h0;
  // Reset pin idles high; a low reset value would fake a programming-mode entry
  localparam pin_s     PIN_RST     = 4'h8;

endpackage

// >>> core/config_option_decode_and_icp.sv
`timescale 1ns/10ps
// Operation
// - Brownout byte bit 7 switches the brown-out detector on or off.
// - Bits 5:4 pick one of four thresholds, 11 lowest, 00 highest.
// - Bit 3 with detector on blocks self-programming while supply is low.
// - Bit 2 set with detector on makes a brown-out issue a reset; clear means none.
// - The brownout option byte reloads into working settings on power-on reset.
// - Watchdog field all ones leaves watchdog off as reset, usable as timer.
// - Alternating code enables watchdog reset, halted in Idle and Power-down.
// - Any other code enables watchdog reset that runs through low-power modes.
// - Active-low programming reset pin moves device in and out of programming mode.
// - Programming data pin is two-way; device drives it only returning data.
// - Programmer supplies the clock; every shifted bit follows its edges.
// - After power-on reset brownout option bits copy into software control bits, freely writable.
module config_option_decode_and_icp #(
  parameter int unsigned SHIFT_W = 8
) (
  // Clock and reset (rst_i is the power-on reset)
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       sys_reload_i,
  // Option bytes from non-volatile memory
  input  wire logic [7:0]                 brownout_option_byte_i,
  input  wire logic [7:0]                 watchdog_option_byte_i,
  // Software control bits
  input  wire logic                       ctl_wr_i,
  input  wire cfg_opt_pkg::bod_cfg_s      ctl_wdata_i,
  // Analog comparator
  input  wire logic                       brownout_low_i,
  // Programming pins
  input  wire logic                       prog_rst_n_i,
  input  wire logic                       prog_serial_clock_i,
  input  wire logic                       prog_serial_data_i,
  output logic                            prog_serial_data_o,
  output logic                            prog_serial_data_oe_n_o,
  // Programming byte port
  input  wire logic                       icp_tx_load_i,
  input  wire logic [SHIFT_W-1:0]         icp_tx_byte_i,
  output logic                            icp_mode_o,
  output logic [SHIFT_W-1:0]              icp_rx_byte_o,
  output logic                            icp_rx_valid_o,
  output logic                            icp_tx_busy_o,
  // Decoded settings
  output cfg_opt_pkg::bod_cfg_s           bod_cfg_o,
  output cfg_opt_pkg::wdt_cfg_s           wdt_cfg_o,
  output logic                            cfg_valid_o,
  output logic                            selfprog_block_o,
  output logic                            brownout_reset_o
);

  localparam int unsigned CNT_W = $clog2(SHIFT_W + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(SHIFT_W);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SHIFT_W - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  if (SHIFT_W < 2 || SHIFT_W > 64) begin : g_chk
    $error("SHIFT_W out of range");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    cfg_opt_pkg::ld_state_e state;
    logic                   por_pend;
    logic                   valid;
    cfg_opt_pkg::bod_cfg_s  bod;
    cfg_opt_pkg::wdt_cfg_s  wdt;
    cfg_opt_pkg::pin_s      sync1;
    cfg_opt_pkg::pin_s      sync2;
    logic                   clk_prev;
    logic                   icp_mode;
    logic [SHIFT_W-1:0]     rx_sh;
    logic [CNT_W-1:0]       rx_cnt;
    logic [SHIFT_W-1:0]     rx_byte;
    logic                   rx_valid;
    logic [SHIFT_W-1:0]     tx_sh;
    logic [CNT_W-1:0]       tx_cnt;
    logic                   dat_o;
    logic                   oe_n;
    logic                   busy;
    logic                   sp_block;
    logic                   bod_rst;
  } st_s;

  st_s st_q;
  st_s st_d;

  function automatic cfg_opt_pkg::bod_cfg_s bod_decode(input logic [7:0] b);
    cfg_opt_pkg::bod_cfg_s c;
    c.brownout_detect_on       = b[cfg_opt_pkg::BOD_ON_BIT];
    c.brownout_threshold_sel   = cfg_opt_pkg::bod_level_e'(
        b[cfg_opt_pkg::BOD_SEL_HI:cfg_opt_pkg::BOD_SEL_LO]);
    c.brownout_blocks_selfprog = b[cfg_opt_pkg::BOD_BLK_BIT];
    c.brownout_reset_on        = b[cfg_opt_pkg::BOD_RST_BIT];
    return c;
  endfunction

  function automatic cfg_opt_pkg::wdt_cfg_s wdt_decode(input logic [3:0] f);
    cfg_opt_pkg::wdt_cfg_s c;
    c.timer_only  = (f == cfg_opt_pkg::WDT_CODE_TIMER);
    c.reset_en    = ~c.timer_only;
    c.run_in_idle = c.reset_en && (f != cfg_opt_pkg::WDT_CODE_STOP);
    return c;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic rise;
    logic fall;
    rise = 1'b0;
    fall = 1'b0;
    st_d = st_q;
    st_d.rx_valid = 1'b0;
    st_d.sync1 = {prog_rst_n_i, prog_serial_clock_i, prog_serial_data_i, brownout_low_i};
    st_d.sync2 = st_q.sync1;
    st_d.clk_prev = st_q.sync2.clk;

    // Load and software control; a reload outranks a software write
    case (st_q.state)
      cfg_opt_pkg::ST_LOAD: begin
        st_d.wdt = wdt_decode(watchdog_option_byte_i[cfg_opt_pkg::WDT_HI:cfg_opt_pkg::WDT_LO]);
        // Brownout settings survive warm reloads; only power-on refreshes them
        if (st_q.por_pend) begin
          st_d.bod = bod_decode(brownout_option_byte_i);
        end
        st_d.por_pend = 1'b0;
        st_d.valid = 1'b1;
        st_d.state = cfg_opt_pkg::ST_RUN;
      end
      cfg_opt_pkg::ST_RUN: begin
        if (sys_reload_i) begin
          st_d.state = cfg_opt_pkg::ST_LOAD;
        end else if (ctl_wr_i) begin
          st_d.bod = ctl_wdata_i;
        end
      end
      default: begin
        st_d.state = cfg_opt_pkg::ST_LOAD;
      end
    endcase

    // Brown-out consequences follow the live comparator
    st_d.sp_block = st_q.bod.brownout_detect_on && st_q.bod.brownout_blocks_selfprog
                    && st_q.sync2.bod_low;
    st_d.bod_rst = st_q.bod.brownout_detect_on && st_q.bod.brownout_reset_on
                   && st_q.sync2.bod_low;

    // Programming port
    st_d.icp_mode = ~st_q.sync2.rst_n;
    rise = st_q.sync2.clk & ~st_q.clk_prev;
    fall = ~st_q.sync2.clk & st_q.clk_prev;
    if (!st_d.icp_mode) begin
      st_d.rx_cnt = CNT_ZERO;
      st_d.tx_cnt = CNT_ZERO;
      st_d.oe_n = 1'b1;
    end else begin
      if (icp_tx_load_i && st_q.tx_cnt == CNT_ZERO && st_q.oe_n) begin
        st_d.tx_sh = icp_tx_byte_i;
        st_d.tx_cnt = CNT_FULL;
      end else if (fall && st_q.tx_cnt != CNT_ZERO) begin
        // Data changes on the falling edge so the programmer samples it on the rise
        st_d.dat_o = st_q.tx_sh[SHIFT_W-1];
        st_d.tx_sh = {st_q.tx_sh[SHIFT_W-2:0], 1'b0};
        st_d.tx_cnt = st_q.tx_cnt - CNT_W'(1);
        st_d.oe_n = 1'b0;
      end else if (fall) begin
        st_d.oe_n = 1'b1;
      end
      if (rise && st_q.oe_n && st_q.tx_cnt == CNT_ZERO) begin
        st_d.rx_sh = {st_q.rx_sh[SHIFT_W-2:0], st_q.sync2.dat};
        if (st_q.rx_cnt == CNT_LAST) begin
          st_d.rx_byte = {st_q.rx_sh[SHIFT_W-2:0], st_q.sync2.dat};
          st_d.rx_valid = 1'b1;
          st_d.rx_cnt = CNT_ZERO;
        end else begin
          st_d.rx_cnt = st_q.rx_cnt + CNT_W'(1);
        end
      end
    end
    st_d.busy = (st_d.tx_cnt != CNT_ZERO) | ~st_d.oe_n;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= '0;
      st_q.state <= cfg_opt_pkg::ST_LOAD;
      st_q.por_pend <= 1'b1;
      st_q.bod <= cfg_opt_pkg::BOD_CFG_RST;
      st_q.wdt <= cfg_opt_pkg::WDT_CFG_RST;
      st_q.sync1 <= cfg_opt_pkg::PIN_RST;
      st_q.sync2 <= cfg_opt_pkg::PIN_RST;
      st_q.oe_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign bod_cfg_o = st_q.bod;
  assign wdt_cfg_o = st_q.wdt;
  assign cfg_valid_o = st_q.valid;
  assign selfprog_block_o = st_q.sp_block;
  assign brownout_reset_o = st_q.bod_rst;
  assign icp_mode_o = st_q.icp_mode;
  assign icp_rx_byte_o = st_q.rx_byte;
  assign icp_rx_valid_o = st_q.rx_valid;
  assign icp_tx_busy_o = st_q.busy;
  assign prog_serial_data_o = st_q.dat_o;
  assign prog_serial_data_oe_n_o = st_q.oe_n;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_por_load;
    st_q.state == cfg_opt_pkg::ST_LOAD && st_q.por_pend;
  endsequence

  sequence s_wdt_load(logic [3:0] code);
    st_q.state == cfg_opt_pkg::ST_LOAD
      && watchdog_option_byte_i[cfg_opt_pkg::WDT_HI:cfg_opt_pkg::WDT_LO] == code;
  endsequence

  sequence s_low_held;
    (brownout_low_i && $stable(bod_cfg_o))[*4];
  endsequence

  AST_BOD_ON: assert property (s_por_load |=>
    bod_cfg_o.brownout_detect_on
      == $past(brownout_option_byte_i[cfg_opt_pkg::BOD_ON_BIT]))
    else $error("detector enable not taken from option byte");
  AST_BOD_SEL: assert property (s_por_load |=>
    bod_cfg_o.brownout_threshold_sel
      == $past(brownout_option_byte_i[cfg_opt_pkg::BOD_SEL_HI:cfg_opt_pkg::BOD_SEL_LO]))
    else $error("threshold select not taken from option byte");
  AST_BOD_BLOCK: assert property (s_low_held |->
    selfprog_block_o == (bod_cfg_o.brownout_detect_on && bod_cfg_o.brownout_blocks_selfprog))
    else $error("self-programming block wrong under low supply");
  AST_BOD_NO_BLOCK: assert property (!bod_cfg_o.brownout_blocks_selfprog[*2]
    |-> !selfprog_block_o)
    else $error("self-programming blocked while allowed");
  AST_BOD_RESET: assert property (s_low_held |->
    brownout_reset_o == (bod_cfg_o.brownout_detect_on && bod_cfg_o.brownout_reset_on))
    else $error("brown-out reset wrong under low supply");
  AST_POR_RELOAD: assert property (s_por_load |=>
    cfg_valid_o && bod_cfg_o == bod_decode($past(brownout_option_byte_i)))
    else $error("brownout byte not reloaded at power-on");
  AST_WDT_TIMER: assert property (s_wdt_load(cfg_opt_pkg::WDT_CODE_TIMER) |=>
    !wdt_cfg_o.reset_en && wdt_cfg_o.timer_only)
    else $error("watchdog not left as plain timer");
  AST_WDT_STOP: assert property (s_wdt_load(cfg_opt_pkg::WDT_CODE_STOP) |=>
    wdt_cfg_o.reset_en && !wdt_cfg_o.run_in_idle)
    else $error("watchdog not halted in low-power modes");
  AST_WDT_RUN: assert property (s_wdt_load(4'h0) |=>
    wdt_cfg_o.reset_en && wdt_cfg_o.run_in_idle)
    else $error("watchdog not running through low-power modes");
  AST_ICP_MODE: assert property (!prog_rst_n_i[*4] |-> icp_mode_o)
    else $error("programming mode not entered");
  AST_OE_IDLE: assert property (!icp_mode_o |-> prog_serial_data_oe_n_o)
    else $error("data pin driven outside programming mode");
  AST_RX_EDGE: assert property (icp_rx_valid_o |->
    $past(icp_mode_o) && $past(st_q.sync2.clk) && !$past(st_q.clk_prev))
    else $error("byte completed without a clock rise");
  AST_CTL_WRITE: assert property (st_q.state == cfg_opt_pkg::ST_RUN && ctl_wr_i
    && !sys_reload_i |=> bod_cfg_o == $past(ctl_wdata_i))
    else $error("software write to control bits lost");
  AST_STABLE: assert property (st_q.state == cfg_opt_pkg::ST_RUN && !ctl_wr_i
    && !sys_reload_i |=> $stable(bod_cfg_o) && $stable(wdt_cfg_o))
    else $error("settings changed between reloads");

endmodule

// >>> testbench/prog_model.sv
`timescale 1ns/10ps
// ****************************************
// Programmer model
// ****************************************
module prog_model (
  // Clock
  input  wire logic clk_i,
  // Device side of the data pin
  input  wire logic dev_dat_i,
  input  wire logic dev_oe_n_i,
  // Pins
  output logic      rst_n_o,
  output logic      sck_o,
  output logic      dat_o
);
  logic drv_en;
  logic drv_v;
  logic last = 1'b0;
  // Undriven wire toggles so a stale bit never reads as valid
  assign dat_o = !dev_oe_n_i ? dev_dat_i : (drv_en ? drv_v : ~last);
  always @(posedge clk_i) last <= dat_o;
  initial begin
    rst_n_o = 1'b1;
    sck_o = 1'b0;
    drv_en = 1'b0;
    drv_v = 1'b0;
  end
  task half();
    repeat (8) @(negedge clk_i);
  endtask
  task mode(input logic on);
    rst_n_o = !on;
  endtask
  // Clock runs only inside a byte; data settles while it is low
  task send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      drv_en = 1'b1;
      drv_v = b[7-i];
      half();
      sck_o = 1'b1;
      half();
      sck_o = 1'b0;
    end
    drv_en = 1'b0;
  endtask
  // Ninth pulse lets the device release the pin
  task recv_byte(output logic [7:0] b);
    for (int i = 0; i < 9; i++) begin
      sck_o = 1'b1;
      half();
      sck_o = 1'b0;
      half();
      if (i < 8) b[7-i] = dat_o;
    end
  endtask
endmodule

// >>> testbench/test_config_option_decode_and_icp.sv
`timescale 1ns/10ps
module test_config_option_decode_and_icp;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sys_reload_i = 1'b0;
  logic [7:0] bo = 8'hcf;
  logic [7:0] wd = 8'hff;
  logic ctl_wr_i = 1'b0;
  cfg_opt_pkg::bod_cfg_s ctl_wdata_i = 5'h00;
  logic low = 1'b0;
  logic tx_load = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic p_rst_n, p_sck, p_dat, d_dat, d_oe_n, mode, rx_v, busy, cvalid, blk, brst;
  logic [7:0] rx_byte, rx_seen, got;
  cfg_opt_pkg::bod_cfg_s bod;
  cfg_opt_pkg::wdt_cfg_s wdt;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [7:0] bos [5] = '{8'hcf, 8'hdb, 8'he7, 8'hf3, 8'h4f};
  logic [3:0] wds [6] = '{4'hf, 4'h5, 4'h0, 4'ha, 4'he, 4'hd};
  always #5 clk_i = ~clk_i;
  config_option_decode_and_icp dut (
    .clk_i(clk_i), .rst_i(rst_i), .sys_reload_i(sys_reload_i),
    .brownout_option_byte_i(bo), .watchdog_option_byte_i(wd),
    .ctl_wr_i(ctl_wr_i), .ctl_wdata_i(ctl_wdata_i), .brownout_low_i(low),
    .prog_rst_n_i(p_rst_n), .prog_serial_clock_i(p_sck), .prog_serial_data_i(p_dat),
    .prog_serial_data_o(d_dat), .prog_serial_data_oe_n_o(d_oe_n),
    .icp_tx_load_i(tx_load), .icp_tx_byte_i(tx_byte), .icp_mode_o(mode),
    .icp_rx_byte_o(rx_byte), .icp_rx_valid_o(rx_v), .icp_tx_busy_o(busy),
    .bod_cfg_o(bod), .wdt_cfg_o(wdt), .cfg_valid_o(cvalid),
    .selfprog_block_o(blk), .brownout_reset_o(brst));
  prog_model prog (.clk_i(clk_i), .dev_dat_i(d_dat), .dev_oe_n_i(d_oe_n),
    .rst_n_o(p_rst_n), .sck_o(p_sck), .dat_o(p_dat));
  always @(posedge clk_i) if (rx_v === 1'b1) rx_seen <= rx_byte;
  // ****************************************
  // Checking and closing
  // ****************************************
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Ceiling is several times the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      wrap_up();
    end
  end
  task cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task por(input logic [7:0] b);
    bo = b;
    rst_i = 1'b1;
    cycles(4);
    rst_i = 1'b0;
    cycles(3);
  endtask
  task wchk(input logic [3:0] c);
    chk(wdt.reset_en, c != 4'hf);
    chk(wdt.timer_only, c == 4'hf);
    if (c != 4'hf) chk(wdt.run_in_idle, c != 4'h5);
  endtask
  task bo_chk(input logic [4:0] c);
    low = 1'b1;
    cycles(5);
    chk(blk, c[4] & c[1]);
    chk(brst, c[4] & c[0]);
    low = 1'b0;
    cycles(5);
    chk({blk, brst}, 8'h00);
  endtask
  task ctl(input logic [4:0] v);
    ctl_wr_i = 1'b1;
    ctl_wdata_i = v;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    foreach (bos[i]) begin
      por(bos[i]);
      chk(cvalid, 8'h01);
      chk(bod, {bos[i][7], bos[i][5:4], bos[i][3], bos[i][2]});
      bo_chk({bos[i][7], bos[i][5:4], bos[i][3], bos[i][2]});
    end
    wchk(4'hf);
    bo = 8'hcf;
    foreach (wds[i]) begin
      wd = {wds[i], 4'hf};
      sys_reload_i = 1'b1;
      cycles(1);
      sys_reload_i = 1'b0;
      cycles(3);
      wchk(wds[i]);
      chk(bod, 8'h03);
    end
    ctl(5'h0a);
    cycles(1);
    chk(bod, 8'h0a);
    ctl(5'h1f);
    cycles(1);
    chk(bod, 8'h1f);
    ctl_wr_i = 1'b0;
    cycles(1);
    chk(bod, 8'h1f);
    bo_chk(5'h1f);
    prog.mode(1'b1);
    cycles(5);
    chk(mode, 8'h01);
    prog.send_byte(8'ha5);
    cycles(5);
    chk(rx_seen, 8'ha5);
    prog.send_byte(8'h3c);
    cycles(5);
    chk(rx_seen, 8'h3c);
    tx_load = 1'b1;
    tx_byte = 8'h96;
    cycles(1);
    tx_load = 1'b0;
    chk(busy, 8'h01);
    prog.recv_byte(got);
    chk(got, 8'h96);
    cycles(5);
    chk({d_oe_n, busy}, 8'h02);
    prog.mode(1'b0);
    cycles(5);
    chk(mode, 8'h00);
    wrap_up();
  end
endmodule
